// ### logic/spi_eeprom_consts.vh
`ifndef SPI_EEPROM_CONSTS_VH
`define SPI_EEPROM_CONSTS_VH

// opcode layout: upper nibble zero, bit 3 carries the top address bit
`define OPC_HI_ZERO          4'h0
`define OPC_ADDR_BIT         3
`define READ_CMD             3'h3
`define WRITE_CMD            3'h2
`define SET_WRITE_LATCH_CMD  3'h6
`define CLEAR_WRITE_LATCH_CMD 3'h4
`define STATUS_READ_CMD      3'h5
`define STATUS_WRITE_CMD     3'h1

// status byte field positions and whole-byte values
`define SR_BUSY_BIT          0
`define SR_LATCH_BIT         1
`define SR_PROT_LO_BIT       2
`define SR_PROT_HI_BIT       3
`define SR_BUSY_VALUE        8'hFF
`define SR_IDLE_VALUE        8'h00

// protect levels
`define PROT_NONE            2'h0
`define PROT_QUARTER         2'h1
`define PROT_HALF            2'h2
`define PROT_ALL             2'h3

// reset values
`define PROT_RESET           2'h0
`define PIN_SYNC_RESET       4'h9

// timing: write cycle in ms, core clock in kHz
`define WRITE_CYCLE_MS       10
`define CORE_CLK_KHZ         40000

`endif

// ### logic/pin_sync2.v
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser for pins from outside the core clock domain
module pin_sync2 #(
  parameter             WIDTH   = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input  wire             core_clk_i,
  input  wire             sys_rst_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_r;  // first stage, read only by the second
  reg [WIDTH-1:0] sync_r;  // second stage, safe to use

  // shift the pins through both stages
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// ### logic/byte_buf2.v
`timescale 1ns/10ps
`default_nettype none

// two-entry buffer with valid/ready on both sides and a flush
module byte_buf2 #(
  parameter WIDTH = 8
) (
  input  wire             core_clk_i,
  input  wire             sys_rst_i,
  input  wire             flush_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg  [WIDTH-1:0] head_r;   // oldest entry
  reg  [WIDTH-1:0] tail_r;   // second entry
  reg  [1:0]       count_r;  // entries held, 0..2
  wire             do_push;
  wire             do_pop;
  wire [1:0]       slot;     // where a pushed word lands

  assign in_ready_o  = (count_r != 2'h2);
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o  = head_r;
  assign do_push     = in_valid_i & in_ready_o;
  assign do_pop      = out_valid_o & out_ready_i;
  assign slot        = count_r - {1'b0, do_pop};

  // storage and occupancy; a flush drops everything
  always @(posedge core_clk_i) begin
    if (sys_rst_i || flush_i) begin
      count_r <= 2'h0;
      head_r  <= {WIDTH{1'b0}};
      tail_r  <= {WIDTH{1'b0}};
    end else begin
      if (do_pop) begin
        head_r <= tail_r;
      end
      if (do_push) begin
        if (slot == 2'h0) begin
          head_r <= in_data_i;
        end else begin
          tail_r <= in_data_i;
        end
      end
      count_r <= count_r + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

endmodule

`default_nettype wire

// ### logic/spi_eeprom_command_core.v
`timescale 1ns/10ps
`default_nettype none
`include "spi_eeprom_consts.vh"

module spi_eeprom_command_core #(
  parameter       ADDR_W      = 9,
  parameter       CNT_W       = 24,
  parameter       PROG_CYCLES = `WRITE_CYCLE_MS * `CORE_CLK_KHZ,
  parameter [1:0] PROT_INIT   = `PROT_RESET
) (
  input  wire core_clk_i,
  input  wire sys_rst_i,
  input  wire cs_n_i,
  input  wire sck_i,
  input  wire si_i,
  input  wire wp_n_i,
  output wire so_o,
  output wire so_oe_o
);

  // one-hot states
  localparam [6:0] ST_IDLE  = 7'h01;  // standby or ignoring until select falls
  localparam [6:0] ST_OPC   = 7'h02;  // shifting in the opcode
  localparam [6:0] ST_ADDR  = 7'h04;  // shifting in the low address byte
  localparam [6:0] ST_WDATA = 7'h08;  // collecting page data
  localparam [6:0] ST_RDATA = 7'h10;  // streaming array data out
  localparam [6:0] ST_STAT  = 7'h20;  // streaming the status byte out
  localparam [6:0] ST_SDATA = 7'h40;  // collecting the new protect bits

  localparam [CNT_W-1:0] PROG_LAST = PROG_CYCLES - 1;

  // synchronised pins and their previous values
  wire [3:0]  pins_s;
  wire        cs_n_s;
  wire        sck_s;
  wire        si_s;
  wire        wp_n_s;
  reg         cs_n_d_r;            // select one cycle back
  reg         sck_d_r;             // clock one cycle back
  wire        cs_fall;
  wire        cs_rise;
  wire        sck_rise;
  wire        sck_fall;

  // command engine
  reg  [6:0]        st_r;          // current state
  reg  [2:0]        bit_r;         // bits of the current byte so far
  reg  [7:0]        rx_r;          // input shift register
  reg               rd_cmd_r;      // address phase belongs to a read
  reg  [ADDR_W-1:0] addr_r;        // byte address counter
  reg  [7:0]        page_r [0:7];  // page data waiting to be committed
  reg  [7:0]        load_r;        // which page slots were loaded
  reg               wr_arm_r;      // array write still allowed to launch
  reg               sr_arm_r;      // status write allowed to launch
  reg               sr_got_r;      // a full status byte arrived
  reg  [1:0]        sr_new_r;      // protect bits to program
  wire [7:0]        rx_byte;       // byte completed on this edge
  wire              shifting;      // states that listen to serial input
  wire              byte_done;

  // nonvolatile state and programming cycle
  reg  [7:0]        mem [0:(1<<ADDR_W)-1];  // the array
  reg  [1:0]        prot_r;        // protect level bits
  reg               wel_r;         // write enable latch
  reg               busy_r;        // internal programming running
  reg               prog_sr_r;     // this cycle programs protect bits
  reg  [CNT_W-1:0]  cnt_r;         // cycles left in programming
  reg  [ADDR_W-4:0] pbase_r;       // page being programmed
  reg  [7:0]        ld_hold_r;     // slots to commit this cycle
  wire              commit_now;
  reg  [7:0]        status_byte;
  integer           i;

  // output side
  wire              sending;
  wire              push_v;
  wire              push_rdy;
  wire [7:0]        push_d;
  wire              pop_v;
  wire              pop_rdy;
  wire [7:0]        pop_d;
  reg  [7:0]        tx_r;          // output shift register
  reg  [2:0]        txc_r;         // bits left in tx_r
  reg               so_r;
  reg               oe_r;

  // true when the address lies in the protected region
  function prot_hit;
    input [ADDR_W-1:0] a;
    input [1:0]        lvl;
    begin
      case (lvl)
        `PROT_QUARTER: prot_hit = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
        `PROT_HALF:    prot_hit = a[ADDR_W-1];
        `PROT_ALL:     prot_hit = 1'b1;
        default:       prot_hit = 1'b0;
      endcase
    end
  endfunction

  // all pins come from the master's domain
  pin_sync2 #(
    .WIDTH   (4),
    .RST_VAL (`PIN_SYNC_RESET)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    ({cs_n_i, sck_i, si_i, wp_n_i}),
    .sync_o     (pins_s)
  );

  assign cs_n_s   = pins_s[3];
  assign sck_s    = pins_s[2];
  assign si_s     = pins_s[1];
  assign wp_n_s   = pins_s[0];
  assign cs_fall  = cs_n_d_r & ~cs_n_s;
  assign cs_rise  = ~cs_n_d_r & cs_n_s;
  assign sck_rise = ~sck_d_r & sck_s & ~cs_n_s;
  assign sck_fall = sck_d_r & ~sck_s & ~cs_n_s;

  // read states do not listen to the input pin
  assign shifting  = st_r[1] | st_r[2] | st_r[3] | st_r[6];
  assign rx_byte   = {rx_r[6:0], si_s};
  assign byte_done = sck_rise & shifting & (bit_r == 3'h7);
  assign commit_now = busy_r & (cnt_r == {CNT_W{1'b0}});

  // edge history of the synchronised pins
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cs_n_d_r <= 1'b1;
      sck_d_r  <= 1'b0;
    end else begin
      cs_n_d_r <= cs_n_s;
      sck_d_r  <= sck_s;
    end
  end

  // status byte as the master sees it
  always @* begin
    status_byte                  = `SR_IDLE_VALUE;
    status_byte[`SR_LATCH_BIT]   = wel_r;
    status_byte[`SR_PROT_LO_BIT] = prot_r[0];
    status_byte[`SR_PROT_HI_BIT] = prot_r[1];
    status_byte[`SR_BUSY_BIT]    = busy_r;
    if (busy_r) begin
      status_byte = `SR_BUSY_VALUE;
    end
  end

  // command decode, address counting and programming control
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r      <= ST_IDLE;
      bit_r     <= 3'h0;
      rx_r      <= 8'h00;
      rd_cmd_r  <= 1'b0;
      addr_r    <= {ADDR_W{1'b0}};
      load_r    <= 8'h00;
      wr_arm_r  <= 1'b0;
      sr_arm_r  <= 1'b0;
      sr_got_r  <= 1'b0;
      sr_new_r  <= 2'h0;
      prot_r    <= PROT_INIT;
      wel_r     <= 1'b0;
      busy_r    <= 1'b0;
      prog_sr_r <= 1'b0;
      cnt_r     <= {CNT_W{1'b0}};
      pbase_r   <= {(ADDR_W-3){1'b0}};
      ld_hold_r <= 8'h00;
    end else begin
      // programming countdown, then finish
      if (busy_r) begin
        if (commit_now) begin
          busy_r <= 1'b0;
          wel_r  <= 1'b0;
          if (prog_sr_r) begin
            prot_r <= sr_new_r;
          end
        end else begin
          cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      // protect pin low kills any write not yet launched
      if (!wp_n_s) begin
        wr_arm_r <= 1'b0;
        sr_arm_r <= 1'b0;
      end
      // bit counting and shifting
      if (sck_rise && shifting) begin
        rx_r  <= rx_byte;
        bit_r <= bit_r + 3'h1;
      end
      if (cs_fall) begin
        // every command starts fresh here
        st_r     <= ST_OPC;
        bit_r    <= 3'h0;
        load_r   <= 8'h00;
        wr_arm_r <= 1'b0;
        sr_arm_r <= 1'b0;
        sr_got_r <= 1'b0;
      end else if (cs_rise) begin
        // select high ends the command; whole bytes launch programming
        if (st_r[3] && wr_arm_r && wp_n_s && (bit_r == 3'h0) && (load_r != 8'h00)
            && !busy_r) begin
          busy_r    <= 1'b1;
          prog_sr_r <= 1'b0;
          cnt_r     <= PROG_LAST;
          pbase_r   <= addr_r[ADDR_W-1:3];
          ld_hold_r <= load_r;
        end else if (st_r[6] && sr_arm_r && wp_n_s && sr_got_r && (bit_r == 3'h0)
                     && !busy_r) begin
          busy_r    <= 1'b1;
          prog_sr_r <= 1'b1;
          cnt_r     <= PROG_LAST;
          ld_hold_r <= 8'h00;
        end
        st_r <= ST_IDLE;
      end else if (byte_done) begin
        if (st_r[1]) begin
          // opcode complete
          if (rx_byte[7:4] != `OPC_HI_ZERO) begin
            st_r <= ST_IDLE;
          end else if (busy_r) begin
            if (rx_byte[2:0] == `STATUS_READ_CMD) begin
              st_r <= ST_STAT;
            end else begin
              st_r <= ST_IDLE;
            end
          end else begin
            case (rx_byte[2:0])
              `READ_CMD: begin
                addr_r[ADDR_W-1] <= rx_byte[`OPC_ADDR_BIT];
                rd_cmd_r         <= 1'b1;
                st_r             <= ST_ADDR;
              end
              `WRITE_CMD: begin
                addr_r[ADDR_W-1] <= rx_byte[`OPC_ADDR_BIT];
                rd_cmd_r         <= 1'b0;
                wr_arm_r         <= wel_r & wp_n_s;
                st_r             <= ST_ADDR;
              end
              `SET_WRITE_LATCH_CMD: begin
                if (wp_n_s) begin
                  wel_r <= 1'b1;
                end
                st_r <= ST_IDLE;
              end
              `CLEAR_WRITE_LATCH_CMD: begin
                wel_r <= 1'b0;
                st_r  <= ST_IDLE;
              end
              `STATUS_READ_CMD: begin
                st_r <= ST_STAT;
              end
              `STATUS_WRITE_CMD: begin
                sr_arm_r <= wel_r & wp_n_s;
                st_r     <= ST_SDATA;
              end
              default: begin
                st_r <= ST_IDLE;
              end
            endcase
          end
        end else if (st_r[2]) begin
          // low address byte complete
          addr_r[7:0] <= rx_byte;
          load_r      <= 8'h00;
          if (rd_cmd_r) begin
            st_r <= ST_RDATA;
          end else begin
            st_r <= ST_WDATA;
          end
        end else if (st_r[3]) begin
          // page byte lands in its slot, low bits advance
          if (wr_arm_r) begin
            page_r[addr_r[2:0]] <= rx_byte;
            load_r[addr_r[2:0]] <= 1'b1;
          end
          addr_r[2:0] <= addr_r[2:0] + 3'h1;
        end else if (st_r[6]) begin
          // new protect level
          sr_new_r <= {rx_byte[`SR_PROT_HI_BIT], rx_byte[`SR_PROT_LO_BIT]};
          sr_got_r <= 1'b1;
        end
      end else if (st_r[4] && push_rdy) begin
        // prefetch the next array byte into the buffer
        addr_r <= addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // array commit at the end of the programming cycle
  always @(posedge core_clk_i) begin
    if (commit_now && !prog_sr_r) begin
      for (i = 0; i < 8; i = i + 1) begin
        if (ld_hold_r[i] && !prot_hit({pbase_r, i[2:0]}, prot_r)) begin
          mem[{pbase_r, i[2:0]}] <= page_r[i];
        end
      end
    end
  end

  // bytes to send go through the two-entry buffer
  assign sending = st_r[4] | st_r[5];
  assign push_v  = sending & ~cs_n_s & ~cs_rise;
  assign push_d  = st_r[5] ? status_byte : mem[addr_r];
  assign pop_rdy = sck_fall & sending & (txc_r == 3'h0);

  byte_buf2 #(
    .WIDTH (8)
  ) u_buf (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .flush_i     (cs_fall | cs_rise),
    .in_valid_i  (push_v),
    .in_ready_o  (push_rdy),
    .in_data_i   (push_d),
    .out_valid_o (pop_v),
    .out_ready_i (pop_rdy),
    .out_data_o  (pop_d)
  );

  // serial output changes on falling clock edges, msb first
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_r  <= 8'h00;
      txc_r <= 3'h0;
      so_r  <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      oe_r <= sending & ~cs_n_s & (oe_r | sck_fall);  // drive from the first data fall on
      if (cs_fall || cs_rise) begin
        txc_r <= 3'h0;
        so_r  <= 1'b0;
      end else if (sck_fall && sending) begin
        if (txc_r == 3'h0) begin
          // start a new byte; an empty buffer sends zeros
          so_r  <= pop_v & pop_d[7];
          tx_r  <= pop_v ? {pop_d[6:0], 1'b0} : 8'h00;
          txc_r <= 3'h7;
        end else begin
          so_r  <= tx_r[7];
          tx_r  <= {tx_r[6:0], 1'b0};
          txc_r <= txc_r - 3'h1;
        end
      end
    end
  end

  assign so_o    = so_r;
  assign so_oe_o = oe_r;

endmodule

`default_nettype wire

// ### verif/spi_eeprom_command_core_props.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the serial command core
module spi_eeprom_command_core_props #(
  parameter PROG_CYCLES = 400000
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic so_o,
  input wire logic so_oe_o
);
  logic       sck_q;      // serial clock one cycle back
  logic [3:0] since_fall; // core cycles since the serial clock fell
  logic [4:0] rise_cnt;   // serial clock rises in this frame
  logic [3:0] cs_hi_cnt;  // core cycles since select went high
  logic [7:0] opc_q;      // first byte seen on the input in this frame

  // edge bookkeeping on the raw pins
  always_ff @(posedge core_clk_i) begin
    sck_q <= sck_i;
    if (sys_rst_i) begin
      since_fall <= 4'hF;
      rise_cnt   <= 5'h00;
      cs_hi_cnt  <= 4'hF;
      opc_q      <= 8'h00;
    end else begin
      // opcode bits as the master clocks them in
      if (!sck_q && sck_i && !cs_n_i && rise_cnt < 5'h08) opc_q <= {opc_q[6:0], si_i};
      // restart on a fall, else count up and saturate
      if (sck_q && !sck_i) since_fall <= 4'h0;
      else if (since_fall != 4'hF) since_fall <= since_fall + 4'h1;
      // frame-local rise count
      if (cs_n_i) rise_cnt <= 5'h00;
      else if (!sck_q && sck_i && rise_cnt != 5'h1F) rise_cnt <= rise_cnt + 5'h01;
      // time spent deselected
      if (!cs_n_i) cs_hi_cnt <= 4'h0;
      else if (cs_hi_cnt != 4'hF) cs_hi_cnt <= cs_hi_cnt + 4'h1;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_reset_quiet: assert property ($fell(sys_rst_i) |-> !so_oe_o && !so_o)
    else $error("output active right after reset");
  a_idle_quiet: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("output driven while deselected");
  a_so_released: assert property (!so_oe_o |-> !so_o)
    else $error("data line not low while released");
  a_bit_on_fall: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o)
    |-> since_fall <= 4'h6)
    else $error("data bit changed away from a clock fall");
  a_oe_needs_cs: assert property ($rose(so_oe_o) |-> !cs_n_i)
    else $error("output enabled without select");
  a_oe_after_byte: assert property ($rose(so_oe_o)
    |-> rise_cnt inside {5'h08, 5'h09, 5'h10, 5'h11})
    else $error("output enabled after wrong bit count");
  a_oe_on_fall: assert property ($rose(so_oe_o) |-> since_fall <= 4'h6)
    else $error("output enabled away from a clock fall");
  a_oe_holds_frame: assert property ($fell(so_oe_o) |-> cs_hi_cnt inside {[1:6]})
    else $error("output dropped inside a frame");
  a_oe_read_opc: assert property ($rose(so_oe_o)
    |-> opc_q[7:4] == 4'h0 && opc_q[2:0] inside {3'h3, 3'h5})
    else $error("output enabled after a non-reading opcode");
endmodule

bind spi_eeprom_command_core spi_eeprom_command_core_props #(
  .PROG_CYCLES(PROG_CYCLES)
) i_props (
  .core_clk_i(core_clk_i),
  .sys_rst_i (sys_rst_i),
  .cs_n_i    (cs_n_i),
  .sck_i     (sck_i),
  .si_i      (si_i),
  .wp_n_i    (wp_n_i),
  .so_o      (so_o),
  .so_oe_o   (so_oe_o)
);
`default_nettype wire

// ### verif/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// mode 0 serial master standing in for the host controller
module spi_host_model (
  input  wire logic core_clk_i,
  input  wire logic so_i,
  output var  logic cs_n_o,
  output var  logic sck_o,
  output var  logic si_o,
  output var  logic wp_n_o
);
  // idle: deselected, clock parked low, protect pin high
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
    wp_n_o = 1'b1;
  end
  // wait n core edges, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // drive the protect pin
  task automatic set_wp(input logic v);
    wp_n_o = v;
  endtask
  // every command starts with a select fall
  task automatic open_frame();
    tick(1);
    cs_n_o = 1'b0;
    tick(4);
  endtask
  // select rises in the low phase after the last bit
  task automatic close_frame();
    tick(2);
    cs_n_o = 1'b1;
    si_o   = ~si_o; // released line shows the inverse
    tick(10);
  endtask
  // one byte each way, msb first, 200 ns period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_o = tx[i];
      tick(4);
      rx[i] = so_i;
      sck_o = 1'b1;
      tick(4);
      sck_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### verif/spi_eeprom_command_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the serial command core
module spi_eeprom_command_core_tb;
  localparam int PROG  = 450;   // shortened programming time
  localparam int LIMIT = 60000; // cycle ceiling for the run
  logic       core_clk_i = 1'b0; // 40 MHz core clock
  logic       sys_rst_i  = 1'b1; // reset held from time zero
  logic       cs_n, sck, si, wp_n;
  wire        so, so_oe;
  int         fail_count = 0;
  int         checks     = 0;
  int         cycles     = 0;
  logic [1:0] prot       = 2'h0;  // expected protect level
  logic [7:0] exp_mem [512];      // expected array image
  logic [7:0] rx;
  logic [8:0] bnd [3] = '{9'h180, 9'h100, 9'h000}; // lowest locked address

  always #12.5 core_clk_i = ~core_clk_i;

  spi_eeprom_command_core #(.PROG_CYCLES(PROG)) i_dut (
    .core_clk_i(core_clk_i),
    .sys_rst_i (sys_rst_i),
    .cs_n_i    (cs_n),
    .sck_i     (sck),
    .si_i      (si),
    .wp_n_i    (wp_n),
    .so_o      (so),
    .so_oe_o   (so_oe)
  );
  spi_host_model i_host (
    .core_clk_i(core_clk_i),
    .so_i      (so),
    .cs_n_o    (cs_n),
    .sck_o     (sck),
    .si_o      (si),
    .wp_n_o    (wp_n)
  );

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      conclude();
    end
  end
  // address inside the expected locked region
  function automatic bit locked(input logic [8:0] t);
    return prot == 2'h3 || (prot == 2'h2 && t >= 9'h100) || (prot == 2'h1 && t >= 9'h180);
  endfunction
  // one-byte command frame
  task automatic cmd(input logic [7:0] op);
    i_host.open_frame();
    i_host.xfer(op, rx);
    i_host.close_frame();
  endtask
  // status read against the expected byte
  task automatic status(input logic [7:0] want);
    i_host.open_frame();
    i_host.xfer(8'h05, rx);
    i_host.xfer(8'h00, rx);
    i_host.close_frame();
    check(rx, want);
  endtask
  // busy pattern, ignored latch set and read, then idle with latch cleared
  task automatic prog_tail();
    status(8'hFF);
    cmd(8'h06);
    i_host.open_frame();
    i_host.xfer(8'h03, rx);
    i_host.xfer(8'h00, rx);
    i_host.xfer(8'h00, rx);
    i_host.close_frame();
    check(rx, 8'h00);
    i_host.tick(PROG);
    status({4'h0, prot, 2'b00});
  endtask
  // latch then page write of n bytes counting up from d0
  task automatic page_write(input logic [8:0] a, input int n, input logic [7:0] d0);
    logic [8:0] t;
    cmd(8'h06);
    i_host.open_frame();
    i_host.xfer({4'h0, a[8], 3'h2}, rx);
    i_host.xfer(a[7:0], rx);
    for (int k = 0; k < n; k++) begin
      t = {a[8:3], a[2:0] + 3'(k)};
      i_host.xfer(d0 + 8'(k), rx);
      if (!locked(t)) exp_mem[t] = d0 + 8'(k);
    end
    i_host.close_frame();
    prog_tail();
  endtask
  // new protect level through the status write
  task automatic set_prot(input logic [1:0] lvl);
    cmd(8'h06);
    i_host.open_frame();
    i_host.xfer(8'h01, rx);
    i_host.xfer({4'h0, lvl, 2'b00}, rx);
    i_host.close_frame();
    prot = lvl;
    prog_tail();
  endtask
  // sequential read of n bytes with opcode-like filler on the input
  task automatic read_cmp(input logic [8:0] a, input int n);
    i_host.open_frame();
    i_host.xfer({4'h0, a[8], 3'h3}, rx);
    i_host.xfer(a[7:0], rx);
    for (int k = 0; k < n; k++) begin
      i_host.xfer(8'h02 ^ 8'(k), rx);
      check(rx, exp_mem[a + 9'(k)]);
    end
    i_host.close_frame();
  endtask

  // main sequence
  initial begin
    i_host.tick(20);
    sys_rst_i = 1'b0;
    i_host.tick(3);
    status(8'h00);
    cmd(8'h06);
    status(8'h02);
    cmd(8'h04);
    status(8'h00);
    cmd(8'h06);
    sys_rst_i = 1'b1;
    i_host.tick(20);
    sys_rst_i = 1'b0;
    i_host.tick(3);
    status(8'h00);
    $display("test 1 done");
    page_write(9'h000, 8, 8'hA0);
    page_write(9'h002, 1, 8'h30);
    page_write(9'h1FE, 10, 8'hC0);
    read_cmp(9'h1FB, 8);
    read_cmp(9'h000, 8);
    $display("test 2 done");
    foreach (bnd[i]) begin
      // malformed opcodes leave the output released
      i_host.open_frame();
      i_host.xfer(i == 0 ? 8'h83 : 8'h07, rx);
      i_host.xfer(8'h00, rx);
      check({7'h00, so_oe}, 8'h00);
      i_host.close_frame();
    end
    i_host.open_frame();
    i_host.xfer(8'h02, rx);
    i_host.xfer(8'h05, rx);
    i_host.xfer(8'h5A, rx);
    i_host.close_frame();
    status(8'h00);
    cmd(8'h06);
    i_host.open_frame();
    i_host.xfer(8'h02, rx);
    i_host.xfer(8'h06, rx);
    i_host.xfer(8'h5B, rx);
    i_host.set_wp(1'b0);
    i_host.tick(3);
    i_host.set_wp(1'b1);
    i_host.close_frame();
    cmd(8'h04);
    status(8'h00);
    read_cmp(9'h004, 3);
    $display("test 3 done");
    page_write(9'h17F, 2, 8'h11);
    page_write(9'h0FF, 2, 8'h21);
    for (int l = 1; l <= 3; l++) begin
      set_prot(2'(l));
      page_write(bnd[l-1], 1, 8'h40 + 8'(l));
      page_write(bnd[l-1] - 9'h001, 1, 8'h50 + 8'(l));
      read_cmp(9'h0FF, 2);
      read_cmp(9'h17F, 2);
      read_cmp(9'h1FF, 2);
    end
    set_prot(2'h0);
    $display("test 4 done");
    conclude();
  end
endmodule
`default_nettype wire
